//--- dcf_fifo.sv
`timescale 1ns/1ps
// sixteen by five fifo with pin-level load and unload clocks
module dcf_fifo #(
    parameter int DEPTH = dcf_pkg::DEPTH,
    parameter int WIDTH = dcf_pkg::WIDTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic load_clock_i,
    input wire logic unload_clock_i,
    input wire logic fifo_reset_n_i,
    input wire logic out_enable_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic [WIDTH-1:0] q_o,
    output logic q_oe_o,
    output logic full_n_o,
    output logic almost_full_n_o,
    output logic empty_n_o,
    output logic almost_empty_n_o
);
    logic load_rise;
    logic unload_rise;
    logic fifo_reset_n;
    logic oe_level;
    logic [WIDTH-1:0] data_level;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [dcf_pkg::PTR_W-1:0] wr_ptr_r;
    logic [dcf_pkg::PTR_W-1:0] rd_ptr_r;
    logic [dcf_pkg::PTR_W-1:0] wr_ptr_nxt;
    logic [dcf_pkg::PTR_W-1:0] rd_ptr_nxt;
    logic [dcf_pkg::CNT_W-1:0] count_r;
    logic [dcf_pkg::CNT_W-1:0] count_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;
    logic full_n_r;
    logic almost_full_n_r;
    logic empty_n_r;
    logic almost_empty_n_r;
    logic is_full;
    logic is_empty;
    logic do_write;
    logic do_read;

    // pin samplers; all pin logic is brought into the mclk domain
    dcf_pin_sync #(.W(1), .RST_VAL(1'b0)) u_load_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(load_clock_i),
        .level_o(),
        .rise_o(load_rise)
    );

    dcf_pin_sync #(.W(1), .RST_VAL(1'b0)) u_unload_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(unload_clock_i),
        .level_o(),
        .rise_o(unload_rise)
    );

    dcf_pin_sync #(.W(1), .RST_VAL(1'b0)) u_reset_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(fifo_reset_n_i),
        .level_o(fifo_reset_n),
        .rise_o()
    );

    dcf_pin_sync #(.W(1), .RST_VAL(1'b0)) u_oe_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(out_enable_i),
        .level_o(oe_level),
        .rise_o()
    );

    dcf_pin_sync #(.W(WIDTH), .RST_VAL('0)) u_data_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(data_i),
        .level_o(data_level),
        .rise_o()
    );

    // state decode
    assign is_full = (count_r == dcf_pkg::CNT_FULL);
    assign is_empty = (count_r == dcf_pkg::CNT_RST);
    assign do_write = load_rise & ~is_full & fifo_reset_n;
    assign do_read = unload_rise & ~is_empty & fifo_reset_n;

    // pointer and count next values
    assign wr_ptr_nxt = do_write ? wr_ptr_r + 4'h1 : wr_ptr_r;
    assign rd_ptr_nxt = do_read ? rd_ptr_r + 4'h1 : rd_ptr_r;
    assign count_nxt = count_r + {4'h0, do_write} - {4'h0, do_read};

    // head word: written word falls through when store was empty
    assign q_nxt = (do_write && (is_empty || (do_read && count_r == dcf_pkg::CNT_ONE)))
                   ? data_level : mem_r[rd_ptr_nxt];

    // storage array, never reset; filtered data lags its pins one cycle more than the load
    // detection does, so the word taken is the one sampled just before the rise
    always_ff @(posedge mclk_i) begin
        if (do_write) begin
            mem_r[wr_ptr_r] <= data_level;
        end
    end

    // pointers, count and flags; reset pin clears control state only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= dcf_pkg::PTR_RST;
            rd_ptr_r <= dcf_pkg::PTR_RST;
            count_r <= dcf_pkg::CNT_RST;
            full_n_r <= dcf_pkg::FULL_N_RST;
            almost_full_n_r <= dcf_pkg::ALMOST_FULL_N_RST;
            empty_n_r <= dcf_pkg::EMPTY_N_RST;
            almost_empty_n_r <= dcf_pkg::ALMOST_EMPTY_N_RST;
        end else if (!fifo_reset_n) begin
            wr_ptr_r <= dcf_pkg::PTR_RST;
            rd_ptr_r <= dcf_pkg::PTR_RST;
            count_r <= dcf_pkg::CNT_RST;
            full_n_r <= dcf_pkg::FULL_N_RST;
            almost_full_n_r <= dcf_pkg::ALMOST_FULL_N_RST;
            empty_n_r <= dcf_pkg::EMPTY_N_RST;
            almost_empty_n_r <= dcf_pkg::ALMOST_EMPTY_N_RST;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            full_n_r <= (count_nxt != dcf_pkg::CNT_FULL);
            almost_full_n_r <= (count_nxt != dcf_pkg::CNT_ALMOST_FULL);
            empty_n_r <= (count_nxt != dcf_pkg::CNT_RST);
            almost_empty_n_r <= (count_nxt != dcf_pkg::CNT_ONE);
        end
    end

    // output word register; reset pin does not clear it, it keeps loading the word at the read pointer
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= dcf_pkg::Q_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // data pins uninverted; enable only drives q_oe_o, data and flags always driven
    assign q_o = q_r;
    assign q_oe_o = oe_level;
    assign full_n_o = full_n_r;
    assign almost_full_n_o = almost_full_n_r;
    assign empty_n_o = empty_n_r;
    assign almost_empty_n_o = almost_empty_n_r;
endmodule // dcf_fifo

//--- dcf_pkg.sv
package dcf_pkg;
    localparam int DEPTH = 16;
    localparam int WIDTH = 5;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ALMOST_FULL = 5'h0F;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
    localparam logic [WIDTH-1:0] Q_RST = 5'h00;
    // flag values after reset (active low flags)
    localparam logic FULL_N_RST = 1'b1;
    localparam logic ALMOST_FULL_N_RST = 1'b1;
    localparam logic EMPTY_N_RST = 1'b0;
    localparam logic ALMOST_EMPTY_N_RST = 1'b1;
    // pin sampling and clock figures
    localparam int MCLK_MHZ = 125;
    localparam int PIN_CLK_MAX_MHZ = 40;
    localparam int PIN_PERIOD_CYC = MCLK_MHZ / PIN_CLK_MAX_MHZ;
endpackage

//--- dcf_pin_sync.sv
`timescale 1ns/1ps
// three-stage pin sampler; a change counts once stages two and three agree
module dcf_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] agree;
    logic [W-1:0] level_nxt;

    // per-bit filtered level
    assign agree = ~(s2_r ^ s3_r);
    assign level_nxt = (agree & s3_r) | (~agree & level_r);
    assign rise_o = level_nxt & ~level_r;
    assign level_o = level_r;

    // sampling chain; s1 feeds s2 only
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end
endmodule // dcf_pin_sync

//--- dcf_fifo_sva.sv
`timescale 1ns/1ps
// flag and data checks at the fifo pins
module dcf_fifo_sva #(
    parameter int WIDTH = dcf_pkg::WIDTH
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic load_clock_i,
    input wire logic unload_clock_i,
    input wire logic fifo_reset_n_i,
    input wire logic out_enable_i,
    input wire logic [WIDTH-1:0] q_o,
    input wire logic q_oe_o,
    input wire logic full_n_o,
    input wire logic almost_full_n_o,
    input wire logic empty_n_o,
    input wire logic almost_empty_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // flag relations and transitions, output enable and head word hold
    empty_state_a: assert property (!empty_n_o |-> almost_empty_n_o && full_n_o) else $error("empty flags");
    full_entry_a: assert property ($fell(full_n_o) |-> !$past(almost_full_n_o)) else $error("full entry");
    fill_first_a: assert property ($rose(empty_n_o) |-> !almost_empty_n_o) else $error("fill first");
    drain_last_a: assert property ($fell(empty_n_o) |-> almost_empty_n_o) else $error("drain last");
    reset_flags_a: assert property (!fifo_reset_n_i [*6] |-> full_n_o && almost_full_n_o
        && !empty_n_o && almost_empty_n_o) else $error("reset flags");
    oe_off_a: assert property (!out_enable_i [*5] |-> !q_oe_o) else $error("oe off");
    quiet_flags_a: assert property ((!load_clock_i && !unload_clock_i && fifo_reset_n_i) [*8] |->
        $stable({full_n_o, almost_full_n_o, empty_n_o, almost_empty_n_o})) else $error("flags moved");
    head_hold_a: assert property ((empty_n_o && !unload_clock_i && fifo_reset_n_i) [*6] |->
        $stable(q_o)) else $error("head moved");
    // main scenarios
    cover property ($fell(full_n_o));
    cover property ($rose(empty_n_o));
    cover property ($fell(q_oe_o));
endmodule // dcf_fifo_sva

bind dcf_fifo dcf_fifo_sva #(.WIDTH(WIDTH)) i_dcf_fifo_sva (.mclk_i, .rst_i, .load_clock_i, .unload_clock_i,
    .fifo_reset_n_i, .out_enable_i, .q_o, .q_oe_o, .full_n_o, .almost_full_n_o, .empty_n_o, .almost_empty_n_o);

//--- dcf_peer.sv
`timescale 1ns/1ps
// producer and consumer logic on the fifo pins
module dcf_peer (
    input wire logic mclk_i,
    output logic load_clock_o,
    output logic unload_clock_o,
    output logic [dcf_pkg::WIDTH-1:0] data_o
);
    initial begin
        {unload_clock_o, load_clock_o} = 2'h0;
        data_o = 5'h00;
    end
    // three cycles high, three low: pin clocks stay well below the limit
    // sel bit one raises the unload clock, bit zero the load clock
    task automatic pulse(input logic [1:0] sel, input logic [dcf_pkg::WIDTH-1:0] w);
        @(negedge mclk_i) data_o = w;
        @(negedge mclk_i) {unload_clock_o, load_clock_o} = sel;
        repeat (3) @(negedge mclk_i);
        {unload_clock_o, load_clock_o} = 2'h0;
        data_o = ~w; // hold over, stale word not kept
        repeat (3) @(negedge mclk_i);
    endtask
endmodule // dcf_peer

//--- dcf_fifo_tb.sv
`timescale 1ns/1ps
// fills, overfills, drains and resets the fifo
module dcf_fifo_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic fifo_reset_n_i = 1'b1;
    logic out_enable_i = 1'b1;
    logic load_clock_i, unload_clock_i, q_oe_o, full_n_o, almost_full_n_o, empty_n_o, almost_empty_n_o;
    logic [4:0] data_i, q_o;
    logic [4:0] exp_q[$];
    int cnt = 0;
    int mismatches = 0;
    int samples_checked = 0;
    always #4 mclk_i = ~mclk_i;
    dcf_peer i_dcf_peer (.mclk_i, .load_clock_o(load_clock_i), .unload_clock_o(unload_clock_i), .data_o(data_i));
    dcf_fifo i_dcf_fifo (.mclk_i, .rst_i, .load_clock_i, .unload_clock_i, .fifo_reset_n_i, .out_enable_i,
        .data_i, .q_o, .q_oe_o, .full_n_o, .almost_full_n_o, .empty_n_o, .almost_empty_n_o);
    task automatic check(input logic [4:0] got, input logic [4:0] want);
        samples_checked++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch at %0t ns: got %h want %h", $time, got, want);
        end
    endtask
    // flags against the expected count, head word against the expected queue
    task automatic flags();
        repeat (6) @(negedge mclk_i);
        check({1'b0, full_n_o, almost_full_n_o, empty_n_o, almost_empty_n_o},
            {1'b0, cnt != 16, cnt != 15, cnt != 0, cnt != 1});
        if (cnt > 0 && q_oe_o === 1'b1) check(q_o, exp_q[0]);
    endtask
    task automatic op(input logic ul, input logic [4:0] w);
        i_dcf_peer.pulse(ul ? 2'h2 : 2'h1, w);
        if (ul && cnt > 0) begin
            void'(exp_q.pop_front());
            cnt--;
        end
        if (!ul && cnt < 16) begin
            exp_q.push_back(w);
            cnt++;
        end
        flags();
    endtask
    // load and unload edges together: oldest word out, new word in
    task automatic swap(input logic [4:0] w);
        i_dcf_peer.pulse(2'h3, w);
        if (cnt < 16) exp_q.push_back(w);
        if (cnt > 0) void'(exp_q.pop_front());
        cnt = exp_q.size();
        flags();
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge mclk_i);
        rst_i = 1'b0;
        flags();
        for (int i = 0; i < 17; i++) op(1'b0, 5'h1F - i[4:0]);
        out_enable_i = 1'b0;
        flags();
        check({4'h0, q_oe_o}, 5'h00);
        out_enable_i = 1'b1;
        for (int i = 0; i < 17; i++) op(1'b1, 5'h00);
        for (int i = 0; i < 3; i++) op(1'b0, i[4:0]);
        fifo_reset_n_i = 1'b0;
        exp_q.delete();
        cnt = 0;
        flags();
        fifo_reset_n_i = 1'b1;
        op(1'b0, 5'h0A);
        swap(5'h15);
        give_verdict();
    end
    // hang guard
    initial begin
        #20000;
        mismatches++;
        give_verdict();
    end
endmodule // dcf_fifo_tb
